/* File: shared/ocs_pkg.sv */
// shared constants and types of the serial command sequencer
package ocs_pkg;

   // master clock
   localparam int MCLK_MHZ = 20;

   // blink half period, in microseconds and in master cycles
   localparam int BLINK_HALF_US = 500000;
   localparam int BLINK_HALF_CYC = BLINK_HALF_US * MCLK_MHZ;
   localparam int BLINK_CNT_W = 24;

   // serial byte framing
   localparam int BYTE_BITS = 8;
   localparam int BIT_CNT_W = 4;

   // data buffer toward video ram
   localparam int FIFO_DEPTH = 32;
   localparam int VRAM_W = 10;
   localparam int VRAM_OFF_BIT = 9;
   localparam int VRAM_BLINK_BIT = 8;

   // reserved character codes per variant
   localparam logic [7:0] CODE_OFF_SMALL = 8'h7E;
   localparam logic [7:0] CODE_OFF_LARGE = 8'hFE;
   localparam logic [7:0] CODE_END_SMALL = 8'h7F;
   localparam logic [7:0] CODE_END_LARGE = 8'hFF;
   localparam logic [7:0] CODE_MASK_SMALL = 8'h7F;
   localparam logic [7:0] CODE_MASK_LARGE = 8'hFF;

   // leading byte classes
   localparam logic [7:0] VRAM_HDR_MASK = 8'hFE;
   localparam logic [7:0] VRAM_HDR = 8'h80;
   localparam logic [7:0] TWO_HDR_MASK = 8'hF0;
   localparam logic [7:0] TWO_HDR = 8'hB0;
   localparam int BLINK_FIELD_BIT = 0;

   // two-byte test commands
   localparam logic [15:0] CMD_XTAL_OUT = 16'hB03F;
   localparam logic [15:0] CMD_LC_OUT = 16'hB03E;
   localparam logic [15:0] CMD_TEST_CLEAR = 16'hB000;

   // decoder states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SECOND = 3'b010,
      ST_CONTIG = 3'b100
   } ocs_state_type;

endpackage : ocs_pkg

/* File: design/ocs_fifo.sv */
// synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module ocs_fifo
   import ocs_pkg::*;
#(
   parameter int WIDTH = VRAM_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } ocs_fifo_state_type;

   ocs_fifo_state_type q, d;
   logic push, pop;

   assign o_in_ready = (q.count != DEPTH[AW:0]);
   assign o_out_valid = (q.count != '0);
   assign o_out_data = q.mem[q.rd_ptr];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wr_ptr] = i_in_data;
         d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         d.count = q.count + 1'b1;
      end
      else if (pop && !push)
      begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : ocs_fifo

/* File: design/ocs_byte_rx.sv */
// serial byte receiver framed by active-low chip select
`timescale 1ns/10ps
module ocs_byte_rx
   import ocs_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // serial pins
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_sdata,
   // received bytes
   output logic o_byte_valid,
   output logic [BYTE_BITS-1:0] o_byte,
   output logic o_frame_end
);

   typedef struct packed
   {
      logic sclk_prev;
      logic cs_n_prev;
      logic [BYTE_BITS-1:0] shift;
      logic [BIT_CNT_W-1:0] bits;
      logic byte_valid;
      logic [BYTE_BITS-1:0] data;
      logic frame_end;
   } ocs_rx_state_type;

   ocs_rx_state_type q, d;

   always_comb
   begin
      d = q;
      d.sclk_prev = i_sclk;
      d.cs_n_prev = i_cs_n;
      d.byte_valid = 1'b0;
      d.frame_end = i_cs_n && !q.cs_n_prev;
      if (i_cs_n)
      begin
         d.bits = '0;
      end
      else if (i_sclk && !q.sclk_prev)
      begin
         // msb first
         d.shift = {q.shift[BYTE_BITS-2:0], i_sdata};
         if (q.bits == BIT_CNT_W'(BYTE_BITS - 1))
         begin
            d.bits = '0;
            d.byte_valid = 1'b1;
            d.data = {q.shift[BYTE_BITS-2:0], i_sdata};
         end
         else
         begin
            d.bits = q.bits + 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= '{sclk_prev: 1'b0, cs_n_prev: 1'b1, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign o_byte_valid = q.byte_valid;
   assign o_byte = q.data;
   assign o_frame_end = q.frame_end;

endmodule : ocs_byte_rx

/* File: design/ocs_sequencer.sv */
// command decoder, video ram write stream, blink and test-mode outputs
//
// How it works
// - character code picks one of 128 patterns, or 256 on the large variant
// - code FEH means display-off data on both variants, 7EH only on the small variant
// - blink attribute one makes that character position blink
// - blink attribute zero shows the character steadily
// - contiguous write: one attribute byte, then any number of character codes
// - contiguous write ends on chip select high or end code 7FH/FFH
// - test frequency output only while the test pin is high
// - command B03FH routes the crystal or multiplied frequency to vertical sync out
// - vertical sync stops while that frequency is output
// - dot-clock test puts lc frequency on horizontal sync out instead
// - dot oscillator stops while display is on and line sync is low
// - test mode ends by clear command or test pin low
// - test mode clear command is B000H
`timescale 1ns/10ps
module ocs_sequencer
   import ocs_pkg::*;
#(
   parameter bit LARGE_CHARSET = 1'b0,
   parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC,
   parameter int DEPTH = FIFO_DEPTH
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // serial command pins
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_sdata,
   output logic o_busy,
   // decoded commands toward the rest of the controller
   output logic o_cmd_valid,
   output logic [BYTE_BITS-1:0] o_cmd_byte,
   output logic o_cmd2_valid,
   output logic [2*BYTE_BITS-1:0] o_cmd2_word,
   output logic o_overrun,
   input wire logic i_overrun_clr,
   // video ram write stream
   output logic o_vram_valid,
   output logic [VRAM_W-1:0] o_vram_data,
   input wire logic i_vram_ready,
   // character being displayed
   input wire logic [BYTE_BITS-1:0] i_disp_code,
   input wire logic i_disp_blink,
   output logic o_char_visible,
   output logic o_blink_phase,
   // sync and oscillators
   input wire logic i_test,
   input wire logic i_display_on,
   input wire logic i_line_sync_in_n,
   input wire logic i_vsync_int,
   input wire logic i_hsync_int,
   input wire logic i_osc_xtal,
   input wire logic i_osc_lc,
   output logic o_vertical_sync_out,
   output logic o_horizontal_sync_out,
   output logic o_dot_osc_run
);

   localparam logic [7:0] CODE_MASK = LARGE_CHARSET ? CODE_MASK_LARGE : CODE_MASK_SMALL;
   localparam logic [7:0] CODE_OFF = LARGE_CHARSET ? CODE_OFF_LARGE : CODE_OFF_SMALL;
   localparam logic [7:0] CODE_END = LARGE_CHARSET ? CODE_END_LARGE : CODE_END_SMALL;

   typedef struct packed
   {
      ocs_state_type state;
      logic [BYTE_BITS-1:0] first;
      logic blink_attr_bit;
      logic cmd_valid;
      logic [BYTE_BITS-1:0] cmd_byte;
      logic cmd2_valid;
      logic [2*BYTE_BITS-1:0] cmd2_word;
      logic overrun;
      logic xtal_test;
      logic lc_test;
      logic vs_out;
      logic hs_out;
      logic dot_run;
      logic [BLINK_CNT_W-1:0] blink_cnt;
      logic blink_phase;
      logic char_visible;
   } ocs_seq_state_type;

   ocs_seq_state_type q, d;

   logic byte_valid;
   logic [BYTE_BITS-1:0] rx_byte;
   logic frame_end;
   logic [BYTE_BITS-1:0] char_code;
   logic [BYTE_BITS-1:0] disp_code;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [VRAM_W-1:0] fifo_in_data;
   logic [2*BYTE_BITS-1:0] word;

   ocs_byte_rx u_rx
   (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_cs_n(i_cs_n),
      .i_sclk(i_sclk),
      .i_sdata(i_sdata),
      .o_byte_valid(byte_valid),
      .o_byte(rx_byte),
      .o_frame_end(frame_end)
   );

   // top code bit forced low on small variant
   assign char_code = rx_byte & CODE_MASK;
   assign disp_code = i_disp_code & CODE_MASK;
   assign word = {q.first, rx_byte};

   // every selected byte between the attribute and the end code is a character
   assign fifo_in_valid = byte_valid && !frame_end && (q.state == ST_CONTIG) && (char_code != CODE_END);
   // display-off code tagged in the stored word
   assign fifo_in_data = {char_code == CODE_OFF, q.blink_attr_bit, char_code};

   ocs_fifo #(
      .WIDTH(VRAM_W),
      .DEPTH(DEPTH)
   ) u_fifo
   (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_in_valid(fifo_in_valid),
      .i_in_data(fifo_in_data),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_vram_valid),
      .o_out_data(o_vram_data),
      .i_out_ready(i_vram_ready)
   );

   always_comb
   begin
      d = q;
      d.cmd_valid = 1'b0;
      d.cmd2_valid = 1'b0;
      if (frame_end)
      begin
         d.state = ST_IDLE;
      end
      else if (byte_valid)
      begin
         case (q.state)
            ST_IDLE:
            begin
               if ((rx_byte & VRAM_HDR_MASK) == VRAM_HDR)
               begin
                  d.blink_attr_bit = rx_byte[BLINK_FIELD_BIT];
                  d.state = ST_CONTIG;
               end
               else if ((rx_byte & TWO_HDR_MASK) == TWO_HDR)
               begin
                  d.first = rx_byte;
                  d.state = ST_SECOND;
               end
               else
               begin
                  d.cmd_valid = 1'b1;
                  d.cmd_byte = rx_byte;
               end
            end
            ST_SECOND:
            begin
               d.cmd2_valid = 1'b1;
               d.cmd2_word = word;
               d.state = ST_IDLE;
               if (i_test)
               begin
                  if (word == CMD_XTAL_OUT)
                  begin
                     d.xtal_test = 1'b1;
                     d.lc_test = 1'b0;
                  end
                  else if (word == CMD_LC_OUT)
                  begin
                     d.lc_test = 1'b1;
                     d.xtal_test = 1'b0;
                  end
                  else if (word == CMD_TEST_CLEAR)
                  begin
                     d.xtal_test = 1'b0;
                     d.lc_test = 1'b0;
                  end
               end
            end
            ST_CONTIG:
            begin
               // end code closes the write, select may stay low
               if (char_code == CODE_END)
               begin
                  d.state = ST_IDLE;
               end
            end
            default:
            begin
               d.state = ST_IDLE;
            end
         endcase
      end

      // sticky overrun, a new loss beats the clear
      if (fifo_in_valid && !fifo_in_ready)
      begin
         d.overrun = 1'b1;
      end
      else if (i_overrun_clr)
      begin
         d.overrun = 1'b0;
      end

      // test pin low leaves test mode
      // test outputs only while pin high
      if (!i_test)
      begin
         d.xtal_test = 1'b0;
         d.lc_test = 1'b0;
      end

      d.vs_out = q.xtal_test ? i_osc_xtal : i_vsync_int;
      // horizontal sync replaced by lc oscillator
      d.hs_out = q.lc_test ? i_osc_lc : i_hsync_int;
      // dot oscillator halted in line sync with display on
      d.dot_run = !(i_display_on && !i_line_sync_in_n);

      // blink phase divider
      if (q.blink_cnt == BLINK_CNT_W'(BLINK_HALF_CYCLES - 1))
      begin
         d.blink_cnt = '0;
         d.blink_phase = !q.blink_phase;
      end
      else
      begin
         d.blink_cnt = q.blink_cnt + 1'b1;
      end

      // blinking hides the character in the off phase
      // display-off code never shows a pattern
      d.char_visible = (disp_code != CODE_OFF) && !(i_disp_blink && q.blink_phase);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= '{state: ST_IDLE, dot_run: 1'b1, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign o_busy = !fifo_in_ready;
   assign o_cmd_valid = q.cmd_valid;
   assign o_cmd_byte = q.cmd_byte;
   assign o_cmd2_valid = q.cmd2_valid;
   assign o_cmd2_word = q.cmd2_word;
   assign o_overrun = q.overrun;
   assign o_char_visible = q.char_visible;
   assign o_blink_phase = q.blink_phase;
   assign o_vertical_sync_out = q.vs_out;
   assign o_horizontal_sync_out = q.hs_out;
   assign o_dot_osc_run = q.dot_run;

endmodule : ocs_sequencer

/* File: test/ocs_seq_monitor.sv */
// assertions on the serial command sequencer ports
`timescale 1ns/10ps
module ocs_seq_monitor
   import ocs_pkg::*;
#(
   parameter bit LARGE_CHARSET = 1'b0
)
(
   // watched ports
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic o_cmd_valid,
   input wire logic [BYTE_BITS-1:0] o_cmd_byte,
   input wire logic o_cmd2_valid,
   input wire logic [2*BYTE_BITS-1:0] o_cmd2_word,
   input wire logic o_vram_valid,
   input wire logic [VRAM_W-1:0] o_vram_data,
   input wire logic i_vram_ready,
   input wire logic [BYTE_BITS-1:0] i_disp_code,
   input wire logic i_disp_blink,
   input wire logic o_char_visible,
   input wire logic o_blink_phase,
   input wire logic i_test,
   input wire logic i_display_on,
   input wire logic i_line_sync_in_n,
   input wire logic i_vsync_int,
   input wire logic i_hsync_int,
   input wire logic o_vertical_sync_out,
   input wire logic o_horizontal_sync_out,
   input wire logic o_dot_osc_run
);
   localparam logic [7:0] OFF = LARGE_CHARSET ? CODE_OFF_LARGE : CODE_OFF_SMALL;
   localparam logic [7:0] ENDC = LARGE_CHARSET ? CODE_END_LARGE : CODE_END_SMALL;
   localparam logic [7:0] MASK = LARGE_CHARSET ? CODE_MASK_LARGE : CODE_MASK_SMALL;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   a_vsync_normal: assert property (!i_test [*2] |=> o_vertical_sync_out == $past(i_vsync_int))
      else $error("vertical sync out not following sync");
   a_hsync_normal: assert property (!i_test [*2] |=> o_horizontal_sync_out == $past(i_hsync_int))
      else $error("horizontal sync out not following sync");
   a_dot_osc_stop: assert property (
      $past(i_rst_n) |-> o_dot_osc_run == !($past(i_display_on) && !$past(i_line_sync_in_n)))
      else $error("dot oscillator run wrong");
   a_char_show: assert property (
      $past(i_rst_n) |-> o_char_visible == (($past(i_disp_code) & MASK) != OFF
         && !($past(i_disp_blink) && $past(o_blink_phase))))
      else $error("character visibility wrong");
   // half period of 8 cycles as set by the bench
   a_blink_half: assert property ($changed(o_blink_phase) |=> $stable(o_blink_phase) [*7] ##1 $changed(o_blink_phase))
      else $error("blink phase period wrong");
   a_cmd2_class: assert property (o_cmd2_valid |-> o_cmd2_word[15:12] == 4'hB)
      else $error("two-byte command of wrong class");
   a_cmd1_class: assert property (o_cmd_valid |-> o_cmd_byte[7:4] != 4'hB && o_cmd_byte[7:1] != 7'h40)
      else $error("one-byte command of wrong class");
   a_vram_code: assert property (o_vram_valid |-> o_vram_data[7:0] != ENDC
      && o_vram_data[VRAM_OFF_BIT] == (o_vram_data[7:0] == OFF) && (LARGE_CHARSET || !o_vram_data[7]))
      else $error("video ram word wrong");
   a_vram_hold: assert property (o_vram_valid && !i_vram_ready |=> o_vram_valid && $stable(o_vram_data))
      else $error("video ram word not held");
   cover property (o_cmd2_valid && o_cmd2_word == CMD_XTAL_OUT);
   cover property (o_vram_valid && o_vram_data[VRAM_BLINK_BIT]);
   cover property (o_vram_valid && o_vram_data[VRAM_OFF_BIT]);
endmodule : ocs_seq_monitor

bind ocs_sequencer ocs_seq_monitor #(.LARGE_CHARSET(LARGE_CHARSET)) i_mon (.*);

/* File: test/ocs_host.sv */
// host model driving the serial command pins
`timescale 1ns/10ps
module ocs_host
#(
   parameter int GAP = 48
)
(
   // clock
   input wire logic i_mclk,
   // serial pins
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_sdata
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdata = 1'b0;
   end
   task automatic put(input logic [7:0] b, input int h);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge i_mclk);
         o_cs_n <= 1'b0;
         o_sclk <= 1'b0;
         o_sdata <= b[i];
         repeat (h) @(posedge i_mclk);
         o_sclk <= 1'b1;
         repeat (h) @(posedge i_mclk);
      end
      @(posedge i_mclk);
      o_sclk <= 1'b0;
      o_sdata <= ~b[0];
      repeat (GAP) @(posedge i_mclk);
   endtask : put
   task automatic done;
      @(posedge i_mclk);
      o_cs_n <= 1'b1;
      repeat (GAP) @(posedge i_mclk);
   endtask : done
endmodule : ocs_host

/* File: test/testbench.sv */
// self-checking bench for the serial command sequencer
`timescale 1ns/10ps
module testbench
   import ocs_pkg::*;
;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_vram_ready = 1'b0;
   logic i_test = 1'b0;
   logic i_overrun_clr = 1'b0;
   logic i_osc_xtal = 1'b0, i_osc_lc = 1'b0, i_vsync_int = 1'b0, i_hsync_int = 1'b0;
   logic i_disp_blink = 1'b0, i_display_on = 1'b0, i_line_sync_in_n = 1'b1;
   logic [7:0] i_disp_code = 8'h00;
   logic i_cs_n, i_sclk, i_sdata;
   logic o_busy, o_cmd_valid, o_cmd2_valid, o_overrun, o_vram_valid, o_char_visible, o_blink_phase;
   logic o_vertical_sync_out, o_horizontal_sync_out, o_dot_osc_run;
   logic [7:0] o_cmd_byte;
   logic [15:0] o_cmd2_word;
   logic [VRAM_W-1:0] o_vram_data;
   logic [VRAM_W-1:0] q[$];
   int err_count = 0;
   int checks = 0;
   int n1 = 0;
   int n2 = 0;

   always #25 i_mclk = ~i_mclk;

   ocs_sequencer #(.BLINK_HALF_CYCLES(8), .DEPTH(FIFO_DEPTH)) i_dut
   (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_cs_n(i_cs_n),
      .i_sclk(i_sclk),
      .i_sdata(i_sdata),
      .o_busy(o_busy),
      .o_cmd_valid(o_cmd_valid),
      .o_cmd_byte(o_cmd_byte),
      .o_cmd2_valid(o_cmd2_valid),
      .o_cmd2_word(o_cmd2_word),
      .o_overrun(o_overrun),
      .i_overrun_clr(i_overrun_clr),
      .o_vram_valid(o_vram_valid),
      .o_vram_data(o_vram_data),
      .i_vram_ready(i_vram_ready),
      .i_disp_code(i_disp_code),
      .i_disp_blink(i_disp_blink),
      .o_char_visible(o_char_visible),
      .o_blink_phase(o_blink_phase),
      .i_test(i_test),
      .i_display_on(i_display_on),
      .i_line_sync_in_n(i_line_sync_in_n),
      .i_vsync_int(i_vsync_int),
      .i_hsync_int(i_hsync_int),
      .i_osc_xtal(i_osc_xtal),
      .i_osc_lc(i_osc_lc),
      .o_vertical_sync_out(o_vertical_sync_out),
      .o_horizontal_sync_out(o_horizontal_sync_out),
      .o_dot_osc_run(o_dot_osc_run)
   );
   ocs_host i_host (.i_mclk(i_mclk), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdata(i_sdata));

   always @(posedge i_mclk)
   begin
      n1 <= n1 + int'(o_cmd_valid);
      n2 <= n2 + int'(o_cmd2_valid);
      {i_osc_xtal, i_osc_lc, i_vsync_int, i_hsync_int, i_disp_blink, i_display_on, i_line_sync_in_n} <= 7'($urandom);
      i_disp_code <= {1'b0, 7'($urandom)};
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic tx(input logic [7:0] b);
      i_host.put(b, 1 + int'($urandom % 2));
   endtask : tx

   task automatic cmd2(input logic [15:0] w);
      tx(w[15:8]);
      tx(w[7:0]);
      i_host.done();
      check(o_cmd2_word, w);
   endtask : cmd2

   task automatic contig(input logic bl, input int n);
      logic [7:0] c;
      tx({7'h40, bl});
      for (int k = 0; k < n; k++)
      begin
         c = k ? 8'($urandom) : 8'h7E;
         if (c[6:0] == 7'h7F)
            c = 8'h41;
         if (q.size() < FIFO_DEPTH)
            q.push_back({c[6:0] == 7'h7E, bl, c & CODE_MASK_SMALL});
         tx(c);
      end
   endtask : contig

   task automatic drain;
      for (int t = 0; t < 500 && q.size() != 0; t++)
      begin
         @(posedge i_mclk);
         if (o_vram_valid === 1'b1 && i_vram_ready === 1'b1)
            check(16'(o_vram_data), 16'(q.pop_front()));
         i_vram_ready <= q.size() != 0 && 1'($urandom);
      end
      @(posedge i_mclk);
      check(16'(o_vram_valid), 16'h0);
   endtask : drain

   task automatic follow(input logic vx, input logic lc);
      logic [3:0] p;
      logic [2:0] s;
      logic [7:0] c;
      repeat (6)
      begin
         @(posedge i_mclk);
         p = {i_osc_xtal, i_vsync_int, i_osc_lc, i_hsync_int};
         s = {i_display_on, i_line_sync_in_n, i_disp_blink};
         c = i_disp_code;
         @(posedge i_mclk);
         check(16'(o_vertical_sync_out), 16'(vx ? p[3] : p[2]));
         check(16'(o_horizontal_sync_out), 16'(lc ? p[1] : p[0]));
         check(16'(o_dot_osc_run), 16'(!(s[2] && !s[1])));
         if (!s[0])
            check(16'(o_char_visible), 16'(c != CODE_OFF_SMALL));
      end
   endtask : follow

   initial
   begin
      logic [7:0] b;
      void'($urandom(32'h7230));
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      for (int k = 1; k <= 5; k++)
      begin
         b = 8'($urandom);
         if (b[7:4] == 4'hB || b[7:1] == 7'h40)
            b = 8'h3C;
         tx(b);
         i_host.done();
         check(16'(o_cmd_byte), 16'(b));
         check(16'(n1), 16'(k));
      end
      contig(1'b1, FIFO_DEPTH + 1);
      check(16'(o_busy), 16'h1);
      check(16'(o_overrun), 16'h1);
      tx(CODE_END_SMALL);
      tx(8'h23);
      i_host.done();
      check(16'(o_cmd_byte), 16'h23);
      i_overrun_clr <= 1'b1;
      drain();
      check(16'(o_overrun), 16'h0);
      i_overrun_clr <= 1'b0;
      contig(1'b0, 4);
      i_host.done();
      drain();
      i_test <= 1'b1;
      cmd2(CMD_XTAL_OUT);
      follow(1'b1, 1'b0);
      cmd2(CMD_TEST_CLEAR);
      follow(1'b0, 1'b0);
      cmd2(CMD_LC_OUT);
      follow(1'b0, 1'b1);
      i_test <= 1'b0;
      repeat (2) @(posedge i_mclk);
      follow(1'b0, 1'b0);
      cmd2(CMD_XTAL_OUT);
      follow(1'b0, 1'b0);
      tx(8'hB0);
      i_host.done();
      tx(8'h12);
      i_host.done();
      check(16'(o_cmd_byte), 16'h12);
      check(16'(n2), 16'h4);
      tally_and_finish();
   end

   initial
   begin
      #2000000;
      err_count++;
      tally_and_finish();
   end
endmodule : testbench
